/* File: design/pattern_output_timing_engine.sv */
// Pattern output timing engine: FIFO, timing engine, hold gate, change detector, APB slave.
// Assumes an APB master on CORE_CLK_I and asynchronous external trigger pins.
// Summary of operation
// - Each active update edge (polarity selectable for the external strobe only) moves next FIFO sample onto port.
// - Each line is input, static output, or pattern output.
// - Retransmit mode replays held FIFO samples from first, in order, forever.
// - Update strobe with empty FIFO sets a software-visible underflow flag.
// - Default update strobe comes from dividing the strobe timebase.
// - Timebase defaults to 100 MHz reference, selectable, never driven out.
// - Arm trigger starts engine; finite run stops by itself or by software.
// - Arm-to-first-strobe delay programmable for the timebase source only, default two timebase ticks.
// - Retriggerable mode: each arm pulse yields full strobe count, then waits.
// - Arm pulses during a running sequence are ignored.
// - Arm trigger is edge sensitive, rising or falling selectable.
// - Exported arm trigger is an active-high pulse.
// - Hold gate is level sensitive, programmable polarity, blocks updates.
// - Hold does not cut a sample in progress; acts from next sample.
// - Internal source: generation resumes at once when hold drops.
// - Other sources: resume after hold drops and a new strobe edge.
// - Change detector enables rise, fall or either per line of both ports.
// - Inputs synchronised first; enabled detector outputs ORed into change event.
// - Changes within one 50 ns window merge into one event.
// - Change event selectable as update strobe; always exported, also as input sample strobe.
`timescale 1ns/1ps
module pattern_output_timing_engine
	import pattern_pkg::*;
(
	// Clock and reset
	input  wire logic        CORE_CLK_I,
	input  wire logic        RST_N_I,
	// APB slave
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [7:0]  PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic      [31:0] PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	// DMA sample stream
	input  wire sample_t     DMA_SAMPLE_I,
	output logic             DMA_READY_O,
	// External triggers and timing sources
	input  wire logic        ARM_TRIGGER_I,
	input  wire logic        HOLD_GATE_A_I,
	input  wire logic        HOLD_GATE_B_I,
	input  wire logic        EXT_STROBE_I,
	input  wire logic        EXT_TIMEBASE_I,
	// Port 0 lines and port 1 inputs
	input  wire logic [31:0] PORT0_IN_I,
	input  wire logic [7:0]  PORT1_IN_I,
	output logic      [31:0] PORT0_OUT_O,
	output logic      [31:0] PORT0_OE_O,
	// Exported events
	output logic             ARM_PULSE_O,
	output logic             UPDATE_STROBE_O,
	output logic             CHANGE_EVENT_O,
	output logic             INPUT_SAMPLE_STROBE_O
);
	////////////////////////////////////////////////////////////////////////////////
	// Registers
	logic [31:0] ctrl_r, divide_r, delay_r, count_r;
	logic [31:0] role_out_r, role_pat_r, static_r, rise0_r, fall0_r, en1_r;
	logic        ufl_r, busy_r;
	logic [31:0] pat_r;
	eng_state_t  state_r;
	logic        wr_acc, start_cmd, stop_cmd, clr_ufl, flush_cmd;
	assign wr_acc    = PSEL_I && PENABLE_I && PWRITE_I;
	assign start_cmd = wr_acc && PADDR_I == OFS_COMMAND && PWDATA_I[CMD_START];
	assign stop_cmd  = wr_acc && PADDR_I == OFS_COMMAND && PWDATA_I[CMD_STOP];
	assign clr_ufl   = wr_acc && PADDR_I == OFS_COMMAND && PWDATA_I[CMD_CLR_UFL];
	assign flush_cmd = wr_acc && PADDR_I == OFS_COMMAND && PWDATA_I[CMD_FLUSH];

	////////////////////////////////////////////////////////////////////////////////
	// Input synchronisers
	logic [45:0] sync1_r, sync2_r, sync3_r;
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			sync1_r <= '0;
			sync2_r <= '0;
			sync3_r <= '0;
		end else begin
			sync1_r <= {EXT_TIMEBASE_I, EXT_STROBE_I, HOLD_GATE_B_I, HOLD_GATE_A_I, ARM_TRIGGER_I,
				PORT1_IN_I, PORT0_IN_I, 1'b0};
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end
	logic [39:0] lines_s, lines_d;
	assign lines_s = sync2_r[40:1];
	assign lines_d = sync3_r[40:1];
	logic arm_s, arm_d, hold_a, hold_b, ext_s, ext_d, etb_s, etb_d;
	assign arm_s  = sync2_r[41];
	assign arm_d  = sync3_r[41];
	assign hold_a = sync2_r[42];
	assign hold_b = sync2_r[43];
	assign ext_s  = sync2_r[44];
	assign ext_d  = sync3_r[44];
	assign etb_s  = sync2_r[45];
	assign etb_d  = sync3_r[45];

	////////////////////////////////////////////////////////////////////////////////
	// Change detector
	logic [39:0] rise_en, fall_en;
	logic [3:0]  win_r;
	logic        chg_hit, chg_r;
	assign rise_en = {en1_r[7:0], rise0_r};
	assign fall_en = {en1_r[15:8], fall0_r};
	assign chg_hit = |((lines_s & ~lines_d & rise_en) | (~lines_s & lines_d & fall_en));
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			win_r <= '0;
			chg_r <= 1'b0;
		end else begin
			chg_r <= 1'b0;
			if (win_r != '0) begin
				win_r <= win_r - 4'h1;
			end else if (chg_hit) begin
				chg_r <= 1'b1;
				win_r <= 4'(CHG_WINDOW_CYC - 1);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Timebase, divider and strobe source
	logic        tb_tick, div_pulse, ext_edge, raw_strobe, hold_act, int_src;
	logic [7:0]  ref_acc_r;
	logic [31:0] div_cnt_r;
	logic        tb_ref_tick;
	assign tb_ref_tick = ref_acc_r >= 8'(CORE_MHZ - TB_REF_MHZ);
	assign tb_tick = (tb_src_t'(ctrl_r[CTRL_TB_LSB +: 2]) == TB_EXT) ? (etb_s && !etb_d) : tb_ref_tick;
	assign int_src = upd_src_t'(ctrl_r[CTRL_SRC_LSB +: 2]) == SRC_TIMEBASE;
	assign ext_edge = ctrl_r[CTRL_UPD_FALL] ? (!ext_s && ext_d) : (ext_s && !ext_d);
	assign hold_act = ctrl_r[CTRL_HOLD_EN] &&
		(((ctrl_r[CTRL_HOLD_SRC] ? hold_b : hold_a)) ^ ctrl_r[CTRL_HOLD_LOW]);
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ref_acc_r <= '0;
		end else begin
			// 100 MHz ticks from 250 MHz by phase accumulation: alternating 2/3 cycle spacing
			ref_acc_r <= tb_ref_tick ? ref_acc_r - 8'(CORE_MHZ - TB_REF_MHZ) : ref_acc_r + 8'(TB_REF_MHZ);
		end
	end
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			div_cnt_r <= '0;
		end else if (state_r != ST_RUN || (hold_act && int_src)) begin
			div_cnt_r <= '0;
		end else if (tb_tick) begin
			div_cnt_r <= (div_cnt_r + 32'h1 >= divide_r) ? 32'h0 : div_cnt_r + 32'h1;
		end
	end
	assign div_pulse = state_r == ST_RUN && tb_tick && (div_cnt_r + 32'h1 >= divide_r);
	always_comb begin
		case (upd_src_t'(ctrl_r[CTRL_SRC_LSB +: 2]))
			SRC_TIMEBASE: raw_strobe = div_pulse;
			SRC_EXT:      raw_strobe = ext_edge && state_r == ST_RUN;
			SRC_CHANGE:   raw_strobe = chg_r && state_r == ST_RUN;
			default:      raw_strobe = 1'b0;
		endcase
	end
	// Hold masks strobes; a held external edge is dropped so resume waits for the next one
	logic upd;
	assign upd = raw_strobe && !hold_act;

	////////////////////////////////////////////////////////////////////////////////
	// Timing engine
	logic        arm_edge, arm_go;
	logic [31:0] dly_cnt_r, left_r;
	assign arm_edge = ctrl_r[CTRL_ARM_FALL] ? (!arm_s && arm_d) : (arm_s && !arm_d);
	assign arm_go   = (ctrl_r[CTRL_ARM_HW] ? arm_edge : start_cmd) && state_r == ST_IDLE;
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			state_r   <= ST_IDLE;
			dly_cnt_r <= '0;
			left_r    <= '0;
		end else if (stop_cmd) begin
			state_r <= ST_IDLE;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (arm_go) begin
						state_r   <= ST_DELAY;
						dly_cnt_r <= delay_r;
						left_r    <= count_r;
					end
				end
				ST_DELAY: begin
					if (!int_src || dly_cnt_r <= 32'h1) begin
						state_r <= ST_RUN;
					end else if (tb_tick) begin
						dly_cnt_r <= dly_cnt_r - 32'h1;
					end
				end
				ST_RUN: begin
					if (upd && ctrl_r[CTRL_FINITE]) begin
						left_r <= left_r - 32'h1;
						if (left_r <= 32'h1) begin
							state_r <= ST_DONE;
						end
					end
				end
				ST_DONE: begin
					state_r <= ctrl_r[CTRL_RETRIG] ? ST_IDLE : ST_DONE;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pattern FIFO with retransmit
	logic [31:0]      mem_r [FIFO_DEPTH];
	logic [FIFO_AW:0] wp_r, rp_r;
	logic             full, empty, push, retx;
	assign retx  = ctrl_r[CTRL_RETX];
	assign full  = (wp_r - rp_r) == (FIFO_AW + 1)'(FIFO_DEPTH);
	assign empty = retx ? (wp_r == '0) : (wp_r == rp_r);
	assign push  = DMA_SAMPLE_I.valid && DMA_READY_O;
	always_ff @(posedge CORE_CLK_I) begin
		if (push) begin
			mem_r[wp_r[FIFO_AW-1:0]] <= DMA_SAMPLE_I.data;
		end
	end
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			wp_r   <= '0;
			rp_r   <= '0;
			pat_r  <= '0;
		end else if (flush_cmd) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			if (push) begin
				wp_r <= wp_r + 1'b1;
			end
			if (upd && !empty) begin
				pat_r <= mem_r[rp_r[FIFO_AW-1:0]];
				if (retx && rp_r + 1'b1 == wp_r) begin
					rp_r <= '0;
				end else begin
					rp_r <= rp_r + 1'b1;
				end
			end
		end
	end
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			DMA_READY_O <= 1'b0;
		end else begin
			DMA_READY_O <= !full && !(push && (wp_r - rp_r) == (FIFO_AW + 1)'(FIFO_DEPTH - 1)) &&
				!(retx && wp_r[FIFO_AW]);
		end
	end
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ufl_r <= 1'b0;
		end else if (upd && empty) begin
			ufl_r <= 1'b1;
		end else if (clr_ufl) begin
			ufl_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Port drive and exported events
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			PORT0_OUT_O           <= '0;
			PORT0_OE_O            <= '0;
			ARM_PULSE_O           <= 1'b0;
			UPDATE_STROBE_O       <= 1'b0;
			CHANGE_EVENT_O        <= 1'b0;
			INPUT_SAMPLE_STROBE_O <= 1'b0;
		end else begin
			PORT0_OUT_O           <= (role_pat_r & pat_r) | (~role_pat_r & static_r);
			PORT0_OE_O            <= role_out_r | role_pat_r;
			ARM_PULSE_O           <= arm_go;
			UPDATE_STROBE_O       <= upd;
			CHANGE_EVENT_O        <= chg_r;
			INPUT_SAMPLE_STROBE_O <= chg_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// APB register file
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ctrl_r     <= CTRL_RST;
			divide_r   <= DIVIDE_RST;
			delay_r    <= DELAY_RST;
			count_r    <= COUNT_RST;
			role_out_r <= '0;
			role_pat_r <= '0;
			static_r   <= '0;
			rise0_r    <= '0;
			fall0_r    <= '0;
			en1_r      <= '0;
		end else if (wr_acc) begin
			case (PADDR_I)
				OFS_CTRL:     ctrl_r     <= PWDATA_I;
				OFS_DIVIDE:   divide_r   <= PWDATA_I;
				OFS_DELAY:    delay_r    <= PWDATA_I;
				OFS_COUNT:    count_r    <= PWDATA_I;
				OFS_ROLE_OUT: role_out_r <= PWDATA_I;
				OFS_ROLE_PAT: role_pat_r <= PWDATA_I;
				OFS_STATIC:   static_r   <= PWDATA_I;
				OFS_RISE_EN0: rise0_r    <= PWDATA_I;
				OFS_FALL_EN0: fall0_r    <= PWDATA_I;
				OFS_EN1:      en1_r      <= {16'h0000, PWDATA_I[15:0]};
				default:      ;
			endcase
		end
	end
	logic [31:0] rd_mux;
	logic        bad_addr;
	always_comb begin
		bad_addr = 1'b0;
		case (PADDR_I)
			OFS_CTRL:     rd_mux = ctrl_r;
			OFS_DIVIDE:   rd_mux = divide_r;
			OFS_DELAY:    rd_mux = delay_r;
			OFS_COUNT:    rd_mux = count_r;
			OFS_ROLE_OUT: rd_mux = role_out_r;
			OFS_ROLE_PAT: rd_mux = role_pat_r;
			OFS_STATIC:   rd_mux = static_r;
			OFS_RISE_EN0: rd_mux = rise0_r;
			OFS_FALL_EN0: rd_mux = fall0_r;
			OFS_EN1:      rd_mux = en1_r;
			OFS_STATUS:   rd_mux = {24'h000000, empty, full, hold_act, state_r, left_r[0], busy_r, ufl_r};
			OFS_LINES_IN: rd_mux = lines_s[31:0];
			OFS_COMMAND:  rd_mux = 32'h0000_0000;
			default: begin
				rd_mux   = 32'h0000_0000;
				bad_addr = 1'b1;
			end
		endcase
	end
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			busy_r    <= 1'b0;
			PRDATA_O  <= '0;
			PSLVERR_O <= 1'b0;
			PREADY_O  <= 1'b0;
		end else begin
			busy_r    <= state_r != ST_IDLE;
			PRDATA_O  <= (PSEL_I && !PWRITE_I) ? rd_mux : 32'h0000_0000;
			PSLVERR_O <= PSEL_I && !PENABLE_I && bad_addr;
			PREADY_O  <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions
	ufl_set_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		upd && empty |=> ufl_r) else $error("underflow not flagged");
	hold_block_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		hold_act |-> !upd) else $error("strobe passed hold");
	arm_ignore_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		state_r == ST_RUN && !stop_cmd |=> state_r != ST_DELAY) else $error("rearmed while running");
	arm_start_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		arm_go && !stop_cmd |=> state_r == ST_DELAY ##0 ARM_PULSE_O) else $error("arm not taken");
	fifo_full_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		full |-> !push) else $error("push into full fifo");
	sample_out_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		upd && !empty && !flush_cmd |=> pat_r == $past(mem_r[rp_r[FIFO_AW-1:0]])) else $error("sample not moved");
	retx_wrap_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		retx && upd && !empty && rp_r + 1'b1 == wp_r && !flush_cmd |=> rp_r == '0) else $error("no replay");
	chg_merge_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		chg_r |=> !chg_r [*8]) else $error("events not merged");
	div_pulse_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		div_pulse |=> !div_pulse) else $error("divider pulse too long");
	cov_run_c: cover property (@(posedge CORE_CLK_I) state_r == ST_DELAY ##[1:40] upd);
	cov_ufl_c: cover property (@(posedge CORE_CLK_I) upd && empty);
	cov_hold_c: cover property (@(posedge CORE_CLK_I) raw_strobe && hold_act);
	cov_chg_c: cover property (@(posedge CORE_CLK_I) chg_r);
endmodule

/* File: shared/pattern_pkg.sv */
// Package: register map, field layouts and timing constants of the pattern output engine.
// Assumes a 32-bit APB master and a 250 MHz core clock.
package pattern_pkg;
	// Clock rate, timebase, change window and FIFO size figures
	localparam int CORE_MHZ          = 250;
	localparam int TB_REF_MHZ        = 100;
	localparam int CHG_WINDOW_NS     = 50;
	localparam int CHG_WINDOW_CYC    = (CHG_WINDOW_NS * CORE_MHZ + 999) / 1000;
	localparam int FIFO_DEPTH        = 16;
	localparam int FIFO_AW           = 4;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_DIVIDE    = 8'h04;
	localparam logic [7:0] OFS_DELAY     = 8'h08;
	localparam logic [7:0] OFS_COUNT     = 8'h0C;
	localparam logic [7:0] OFS_ROLE_OUT  = 8'h10;
	localparam logic [7:0] OFS_ROLE_PAT  = 8'h14;
	localparam logic [7:0] OFS_STATIC    = 8'h18;
	localparam logic [7:0] OFS_RISE_EN0  = 8'h1C;
	localparam logic [7:0] OFS_FALL_EN0  = 8'h20;
	localparam logic [7:0] OFS_EN1       = 8'h24;
	localparam logic [7:0] OFS_STATUS    = 8'h28;
	localparam logic [7:0] OFS_LINES_IN  = 8'h2C;
	localparam logic [7:0] OFS_COMMAND   = 8'h30;
	// Control field positions
	localparam int CTRL_UPD_FALL   = 0;
	localparam int CTRL_SRC_LSB    = 1;
	localparam int CTRL_TB_LSB     = 3;
	localparam int CTRL_ARM_HW     = 5;
	localparam int CTRL_ARM_FALL   = 6;
	localparam int CTRL_RETRIG     = 7;
	localparam int CTRL_RETX       = 8;
	localparam int CTRL_HOLD_EN    = 9;
	localparam int CTRL_HOLD_LOW   = 10;
	localparam int CTRL_HOLD_SRC   = 11;
	localparam int CTRL_FINITE     = 12;
	// Command bits
	localparam int CMD_START       = 0;
	localparam int CMD_STOP        = 1;
	localparam int CMD_CLR_UFL     = 2;
	localparam int CMD_FLUSH       = 3;
	// Reset values
	localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
	localparam logic [31:0] DIVIDE_RST = 32'h0000_0001;
	localparam logic [31:0] DELAY_RST  = 32'h0000_0002;
	localparam logic [31:0] COUNT_RST  = 32'h0000_0004;
	// Update strobe sources
	typedef enum logic [1:0] {
		SRC_TIMEBASE = 2'h0,
		SRC_EXT      = 2'h1,
		SRC_CHANGE   = 2'h2
	} upd_src_t;
	// Timebase sources
	typedef enum logic [1:0] {
		TB_REF  = 2'h0,
		TB_EXT  = 2'h1
	} tb_src_t;
	// Engine states, Gray along idle-delay-run-done
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_DELAY = 2'b01,
		ST_RUN   = 2'b11,
		ST_DONE  = 2'b10
	} eng_state_t;
	// DMA sample carrier
	typedef struct packed {
		logic        valid;
		logic [31:0] data;
	} sample_t;
endpackage

/* File: verif/dma_host_model.sv */
// DMA channel model: offers queued words to the pattern sample FIFO.
// Assumes the engine's ready level on the same clock, one word per accepted edge.
`timescale 1ns/1ps
module dma_host_model
	import pattern_pkg::*;
(
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// Sample stream
	input  wire logic ready_i,
	output sample_t   sample_o
);
	logic [31:0] q [$];

	task automatic load(input logic [31:0] w);
		q.push_back(w);
	endtask

	function automatic int pending();
		return q.size();
	endfunction

	////////////////////////////////////////////////////////////////
	// Offer held until taken; idle data toggles
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sample_o <= '{valid: 1'b0, data: 32'h5A5A_5A5A};
		end else begin
			if (sample_o.valid && ready_i) begin
				void'(q.pop_front());
			end
			if (q.size() > 0) begin
				sample_o <= '{valid: 1'b1, data: q[0]};
			end else begin
				sample_o <= '{valid: 1'b0, data: ~sample_o.data};
			end
		end
	end
endmodule

/* File: verif/tb.sv */
// Testbench: APB register tasks, DMA model, trigger and line stimulus.
// Assumes the engine answers APB with no wait states and a 250 MHz clock.
`timescale 1ns/1ps
module tb
	import pattern_pkg::*;
;
	localparam logic [31:0] FIN = 32'h1 << CTRL_FINITE;
	localparam logic [31:0] RTX = 32'h1 << CTRL_RETX;
	localparam logic [31:0] RTG = 32'h1 << CTRL_RETRIG;
	localparam logic [31:0] AHW = 32'h1 << CTRL_ARM_HW;
	localparam logic [31:0] AFL = 32'h1 << CTRL_ARM_FALL;
	localparam logic [31:0] HEN = 32'h1 << CTRL_HOLD_EN;
	localparam logic [31:0] HLO = 32'h1 << CTRL_HOLD_LOW;

	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, dma_ready;
	logic        arm, hold_a, arm_pulse, upd, chg, in_strobe, ext, re;
	logic [7:0]  paddr, port1_in;
	logic [31:0] pwdata, prdata, port0_out, port0_oe, port0_in, rq;
	logic [2:0]  st_d;
	logic [31:0] capq [$];
	sample_t     dma_s;
	int          num_errors, checks, n_upd, n_arm, n_chg, n_ins, b, a, c;

	pattern_output_timing_engine dut (
		.CORE_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.DMA_SAMPLE_I(dma_s), .DMA_READY_O(dma_ready), .ARM_TRIGGER_I(arm), .HOLD_GATE_A_I(hold_a),
		.HOLD_GATE_B_I(1'b0), .EXT_STROBE_I(ext), .EXT_TIMEBASE_I(1'b0), .PORT0_IN_I(port0_in),
		.PORT1_IN_I(port1_in), .PORT0_OUT_O(port0_out), .PORT0_OE_O(port0_oe), .ARM_PULSE_O(arm_pulse),
		.UPDATE_STROBE_O(upd), .CHANGE_EVENT_O(chg), .INPUT_SAMPLE_STROBE_O(in_strobe)
	);

	dma_host_model u_dma (.clk_i(clk), .rst_n_i(rst_n), .ready_i(dma_ready), .sample_o(dma_s));

	always #2 clk = ~clk;

	////////////////////////////////////////////////////////////////
	// Event counters and output capture three cycles after each update
	always @(posedge clk) begin
		st_d <= {st_d[1:0], upd};
		if (upd === 1'b1) n_upd++;
		if (arm_pulse === 1'b1) n_arm++;
		if (chg === 1'b1) n_chg++;
		if (in_strobe === 1'b1) n_ins++;
		if (st_d[2] === 1'b1) capq.push_back(port0_out & 32'h0000_00FF);
	end

	////////////////////////////////////////////////////////////////
	// Compare, bus and wait tasks
	task automatic close_out();
		if (num_errors == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_cnt(input int got, input int exp);
		checks++;
		if (got != exp) begin
			num_errors++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			num_errors++;
			close_out();
		end
	endtask

	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, ad, d, q, e);
	endtask

	task automatic rd(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] x);
		logic [31:0] q;
		logic        e;
		apb(1'b0, ad, 32'h0000_0000, q, e);
		chk_val(q & m, x);
	endtask

	task automatic cmd(input int bit_no);
		wr(OFS_COMMAND, 32'h1 << bit_no);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic wait_upd(input int target, input int bound);
		int n;
		n = 0;
		while (n_upd < target && n < bound) begin
			@(posedge clk);
			n++;
		end
		if (n_upd < target) begin
			num_errors++;
			close_out();
		end
	endtask

	task automatic fill(input int k);
		int n;
		cmd(CMD_FLUSH);
		for (int i = 0; i < k; i++) u_dma.load(32'(17 * (i + 1)));
		n = 0;
		while (u_dma.pending() > 0 && n < 200) begin
			@(posedge clk);
			n++;
		end
		if (u_dma.pending() > 0) begin
			num_errors++;
			close_out();
		end
	endtask

	task automatic arm_to(input logic v);
		arm <= v;
		idle(12);
	endtask

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		clk = 1'b0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
		pwdata = 32'h0000_0000; arm = 1'b0; hold_a = 1'b0; port0_in = 32'h0000_0000; port1_in = 8'h00;
		st_d = 3'h0; num_errors = 0; checks = 0; n_upd = 0; n_arm = 0; n_chg = 0; n_ins = 0; ext = 1'b0;
		idle(12);
		rst_n <= 1'b1;
		rd(OFS_CTRL, 32'hFFFF_FFFF, CTRL_RST);
		rd(OFS_DIVIDE, 32'hFFFF_FFFF, DIVIDE_RST);
		rd(OFS_DELAY, 32'hFFFF_FFFF, DELAY_RST);
		rd(OFS_COUNT, 32'hFFFF_FFFF, COUNT_RST);
		apb(1'b0, 8'h3C, 32'h0000_0000, rq, re);
		chk_val({31'h0, re}, 32'h1);
		chk_val(rq, 32'h0);
		// Line roles
		wr(OFS_ROLE_OUT, 32'h0000_FF00);
		wr(OFS_ROLE_PAT, 32'h0000_00FF);
		wr(OFS_STATIC, 32'hFFFF_A5FF);
		idle(4);
		chk_val(port0_oe, 32'h0000_FFFF);
		chk_val(port0_out & 32'h0000_FF00, 32'h0000_A500);
		// Finite software-started run
		fill(4);
		wr(OFS_DIVIDE, 32'h0000_0004);
		wr(OFS_CTRL, FIN);
		capq.delete();
		b = n_upd;
		cmd(CMD_START);
		wait_upd(b + 4, 400);
		idle(60);
		chk_cnt(n_upd - b, 4);
		for (int i = 0; i < 4; i++) chk_val(capq[i], 32'(17 * (i + 1)));
		rd(OFS_STATUS, 32'h18, 32'h10);
		cmd(CMD_STOP);
		idle(4);
		rd(OFS_STATUS, 32'h18, 32'h0);
		// Underflow on empty FIFO
		cmd(CMD_START);
		idle(150);
		rd(OFS_STATUS, 32'h1, 32'h1);
		cmd(CMD_STOP);
		cmd(CMD_CLR_UFL);
		rd(OFS_STATUS, 32'h1, 32'h0);
		// Retransmit
		fill(3);
		wr(OFS_CTRL, RTX);
		capq.delete();
		b = n_upd;
		cmd(CMD_START);
		wait_upd(b + 7, 800);
		idle(4);
		cmd(CMD_STOP);
		for (int i = 0; i < 7; i++) chk_val(capq[i], 32'(17 * (i % 3 + 1)));
		// Retriggerable hardware arm, both edges
		fill(2);
		wr(OFS_CTRL, FIN | RTG | RTX | AHW);
		b = n_upd;
		a = n_arm;
		arm <= 1'b1;
		wait_upd(b + 1, 300);
		arm_to(1'b0);
		arm_to(1'b1);
		wait_upd(b + 4, 300);
		idle(60);
		chk_cnt(n_upd - b, 4);
		chk_cnt(n_arm - a, 1);
		arm_to(1'b0);
		arm_to(1'b1);
		wait_upd(b + 8, 300);
		idle(60);
		chk_cnt(n_upd - b, 8);
		wr(OFS_CTRL, FIN | RTG | RTX | AHW | AFL);
		arm_to(1'b0);
		wait_upd(b + 12, 300);
		idle(60);
		chk_cnt(n_upd - b, 12);
		chk_cnt(n_arm - a, 3);
		arm_to(1'b1);
		idle(60);
		chk_cnt(n_upd - b, 12);
		// Hold gate, both polarities
		fill(2);
		wr(OFS_CTRL, RTX | HEN);
		b = n_upd;
		cmd(CMD_START);
		wait_upd(b + 2, 300);
		hold_a <= 1'b1;
		idle(12);
		b = n_upd;
		idle(40);
		chk_cnt(n_upd - b, 0);
		hold_a <= 1'b0;
		wait_upd(b + 1, 30);
		wr(OFS_CTRL, RTX | HEN | HLO);
		idle(12);
		b = n_upd;
		idle(40);
		chk_cnt(n_upd - b, 0);
		hold_a <= 1'b1;
		wait_upd(b + 1, 30);
		cmd(CMD_STOP);
		// External strobe, falling edge; resume needs a new edge after hold drops
		wr(OFS_CTRL, RTX | HEN | (32'h1 << CTRL_UPD_FALL) | (32'h1 << CTRL_SRC_LSB));
		cmd(CMD_START);
		b = n_upd;
		ext <= 1'b1;
		idle(12);
		ext <= 1'b0;
		idle(12);
		hold_a <= 1'b0;
		idle(12);
		chk_cnt(n_upd - b, 0);
		ext <= 1'b1;
		idle(12);
		chk_cnt(n_upd - b, 0);
		ext <= 1'b0;
		idle(12);
		chk_cnt(n_upd - b, 1);
		cmd(CMD_STOP);
		// Change detector
		wr(OFS_RISE_EN0, 32'h0000_0003);
		wr(OFS_FALL_EN0, 32'h0000_0000);
		wr(OFS_EN1, 32'h0000_0100);
		c = n_chg;
		port0_in[0] <= 1'b1;
		idle(8);
		port0_in[1] <= 1'b1;
		idle(40);
		chk_cnt(n_chg - c, 1);
		port0_in <= 32'h0000_0000;
		idle(40);
		chk_cnt(n_chg - c, 1);
		port1_in[0] <= 1'b1;
		idle(40);
		chk_cnt(n_chg - c, 1);
		port1_in[0] <= 1'b0;
		idle(40);
		chk_cnt(n_chg - c, 2);
		chk_cnt(n_ins, 2);
		// Change event as update strobe
		fill(2);
		wr(OFS_CTRL, RTX | (32'h2 << CTRL_SRC_LSB));
		cmd(CMD_START);
		b = n_upd;
		idle(20);
		port0_in[0] <= 1'b1;
		wait_upd(b + 1, 40);
		idle(40);
		chk_cnt(n_upd - b, 1);
		close_out();
	end
endmodule
